// >>> hdl/operation_status_transition_filter.sv
// operation status transition filter with per-slot event registers
//
// Contract
// - falling edge with mask bit sets event
// - rising edge with mask bit sets event
// - falling mask resets to zero
// - rising mask resets to all fifteen bits
// - falling mask reads back, 0 to 32767
// - rising mask reads back, 0 to 32767
// - offset enable joins bits 6, 7
// - offset type codes 0, 64, 128, 192
// - each slot has own readable event register
`include "status_cfg.svh"

module operation_status_transition_filter import status_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input cmd_t cmd,
  input wire logic [`SLOT_COUNT-1:0][`STATUS_WIDTH-1:0] cond_in,
  output rsp_t rsp,
  output logic [`SLOT_COUNT-1:0][1:0] offset_type,
  output logic [`SLOT_COUNT-1:0] offset_on
);

  // clip a written word to the usable bits
  function automatic logic [`STATUS_WIDTH-1:0] usable(input logic [`STATUS_WIDTH-1:0] v);
    usable = v & `USABLE_MASK;
  endfunction

  logic [`STATUS_WIDTH-1:0] ntr_r;
  logic [`STATUS_WIDTH-1:0] ptr_r;
  rsp_t rsp_r;
  logic [`SLOT_COUNT-1:0][1:0] offset_type_r;
  logic [`SLOT_COUNT-1:0] offset_on_r;
  logic [`SLOT_COUNT-1:0][`STATUS_WIDTH-1:0] slot_event;
  logic [`SLOT_COUNT-1:0] slot_clr;
  logic ntr_wr;
  logic ntr_rd;
  logic ptr_wr;
  logic ptr_rd;
  logic evt_rd;
  logic rd_any;
  logic [`STATUS_WIDTH-1:0] sel_event;
  logic [`STATUS_WIDTH-1:0] rd_data;
  rsp_t rsp_nxt;
  logic [1:0] cond0_type;
  logic cond0_on;

  // command decode
  assign ntr_wr = cmd.valid && (cmd.code == CMD_NTR_WR);
  assign ntr_rd = cmd.valid && (cmd.code == CMD_NTR_RD);
  assign ptr_wr = cmd.valid && (cmd.code == CMD_PTR_WR);
  assign ptr_rd = cmd.valid && (cmd.code == CMD_PTR_RD);
  assign evt_rd = cmd.valid && (cmd.code == CMD_EVT_RD);
  assign rd_any = ntr_rd || ptr_rd || evt_rd;

  assign sel_event = slot_event[cmd.slot];

  // read data, bit 15 always zero
  assign rd_data = ntr_rd ? usable(ntr_r) :
                   ptr_rd ? usable(ptr_r) :
                   evt_rd ? usable(sel_event) : '0;
  assign rsp_nxt = '{valid: rd_any, data: rd_data};

  // falling mask register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ntr_r <= `NTR_RESET;
    end else if (ntr_wr) begin
      ntr_r <= usable(cmd.data);
    end
  end

  // rising mask register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ptr_r <= `PTR_RESET;
    end else if (ptr_wr) begin
      ptr_r <= usable(cmd.data);
    end
  end

  // answer register, one cycle after the read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  // per-slot trackers; an event read clears only its slot
  for (genvar s = 0; s < `SLOT_COUNT; s++) begin : g_slot
    // clear pulse for the queried slot
    assign slot_clr[s] = evt_rd && (cmd.slot == `SLOT_BITS'(s));

    slot_event_tracker u_tracker (
      .core_clk(core_clk),
      .rst(rst),
      .cond(cond_in[s]),
      .ptr_mask(ptr_r),
      .ntr_mask(ntr_r),
      .clr(slot_clr[s]),
      .event_r(slot_event[s])
    );

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        offset_on_r[s] <= 1'b0;
        offset_type_r[s] <= OFS_EXACT;
      end else begin
        offset_on_r[s] <= cond_in[s][`OFFSET_ENABLE_BIT];
        offset_type_r[s] <= cond_in[s][`OFFSET_ENABLE_BIT] ?
          cond_in[s][`OFFSET_HI_BIT:`OFFSET_LO_BIT] : OFS_EXACT;
      end
    end
  end

  // outputs straight from flops
  assign rsp = rsp_r;
  assign offset_type = offset_type_r;
  assign offset_on = offset_on_r;

  // helper wires for the checks below
  assign cond0_type = cond_in[0][`OFFSET_HI_BIT:`OFFSET_LO_BIT];
  assign cond0_on = cond_in[0][`OFFSET_ENABLE_BIT];

  // mask reset values
  a_ntr_reset_zero: assert property (@(posedge core_clk)
    $fell(rst) |-> (ntr_r == 16'h0000))
    else $error("falling mask not zero after reset");

  a_ptr_reset_full: assert property (@(posedge core_clk)
    $fell(rst) |-> (ptr_r == 16'h7fff))
    else $error("rising mask not 32767 after reset");

  // mask readback and write storage
  a_ntr_read_back: assert property (@(posedge core_clk) disable iff (rst)
    ntr_rd |=> (rsp_r.valid && rsp_r.data == $past(ntr_r) && !rsp_r.data[15]))
    else $error("falling mask readback wrong");

  a_ptr_read_back: assert property (@(posedge core_clk) disable iff (rst)
    ptr_rd |=> (rsp_r.valid && rsp_r.data == $past(ptr_r) && !rsp_r.data[15]))
    else $error("rising mask readback wrong");

  a_ptr_write_store: assert property (@(posedge core_clk) disable iff (rst)
    ptr_wr ##1 !ptr_wr |-> ##1 (ptr_r == ($past(cmd.data, 2) & 16'h7fff)))
    else $error("rising mask write not stored");

  a_ntr_write_store: assert property (@(posedge core_clk) disable iff (rst)
    ntr_wr |=> (ntr_r == ($past(cmd.data) & 16'h7fff)))
    else $error("falling mask write not stored");

  // slot event query
  a_event_read_slot: assert property (@(posedge core_clk) disable iff (rst)
    evt_rd |=> (rsp_r.valid && rsp_r.data == $past(sel_event)))
    else $error("slot event readback wrong");

  a_answer_only_read: assert property (@(posedge core_clk) disable iff (rst)
    !rd_any |=> !rsp_r.valid)
    else $error("answer without a read");

  // offset type field on slot 0
  a_offset_type_slot: assert property (@(posedge core_clk) disable iff (rst)
    cond0_on |=> (offset_on_r[0] && offset_type_r[0] == $past(cond0_type)))
    else $error("offset type not decoded");

  a_offset_off_exact: assert property (@(posedge core_clk) disable iff (rst)
    !cond0_on |=> (!offset_on_r[0] && offset_type_r[0] == OFS_EXACT))
    else $error("offset type set while disabled");

  // main scenarios
  c_event_read_nonzero: cover property (@(posedge core_clk) disable iff (rst)
    evt_rd ##1 (rsp_r.data != '0));

  c_interpolated_type: cover property (@(posedge core_clk) disable iff (rst)
    cond0_on && cond0_type == OFS_INTERP);

  c_ntr_write_read: cover property (@(posedge core_clk) disable iff (rst)
    ntr_wr ##1 ntr_rd);

endmodule

// >>> hdl/slot_event_tracker.sv
// per-slot edge detection and sticky event register
`include "status_cfg.svh"

module slot_event_tracker import status_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [`STATUS_WIDTH-1:0] cond,
  input wire logic [`STATUS_WIDTH-1:0] ptr_mask,
  input wire logic [`STATUS_WIDTH-1:0] ntr_mask,
  input wire logic clr,
  output logic [`STATUS_WIDTH-1:0] event_r
);

  logic [`STATUS_WIDTH-1:0] prev_r;
  logic [`STATUS_WIDTH-1:0] rise_hit;
  logic [`STATUS_WIDTH-1:0] fall_hit;
  logic [`STATUS_WIDTH-1:0] kept;
  logic [`STATUS_WIDTH-1:0] edge_set;
  logic [`STATUS_WIDTH-1:0] event_nxt;
  logic offset_on;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_r <= '0;
    end else begin
      prev_r <= cond;
    end
  end

  assign rise_hit = cond & ~prev_r & ptr_mask;
  assign fall_hit = ~cond & prev_r & ntr_mask;

  // clear loses against a new edge
  assign kept = clr ? '0 : event_r;
  assign edge_set = (kept | rise_hit | fall_hit) & `USABLE_MASK;
  assign offset_on = cond[`OFFSET_ENABLE_BIT];

  // offset bits follow the type field while the offset enable bit is set
  assign event_nxt = offset_on ?
    ((edge_set & `NON_OFFSET_MASK) | (cond & ~`NON_OFFSET_MASK)) : edge_set;

  // sticky event bits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      event_r <= '0;
    end else begin
      event_r <= event_nxt;
    end
  end

  // check edge capture and stickiness
  a_rise_sets_event: assert property (@(posedge core_clk) disable iff (rst)
    (|(rise_hit & `NON_OFFSET_MASK)) |=> (($past(rise_hit) & `NON_OFFSET_MASK & ~event_r) == '0))
    else $error("rising edge did not set its event bit");

  a_fall_sets_event: assert property (@(posedge core_clk) disable iff (rst)
    (|(fall_hit & `NON_OFFSET_MASK)) |=> (($past(fall_hit) & `NON_OFFSET_MASK & ~event_r) == '0))
    else $error("falling edge did not set its event bit");

  a_event_stays_set: assert property (@(posedge core_clk) disable iff (rst)
    !clr |=> (($past(event_r) & `NON_OFFSET_MASK & ~event_r) == '0))
    else $error("event bit dropped without a clear");

  a_masked_edge_quiet: assert property (@(posedge core_clk) disable iff (rst)
    (clr && !offset_on && rise_hit == '0 && fall_hit == '0) |=> (event_r == '0))
    else $error("cleared event register not zero");

endmodule

// >>> hdl/status_cfg.svh
// constants for the operation status transition filter
`ifndef STATUS_CFG_SVH
`define STATUS_CFG_SVH

// word size and the part of it software may use
`define STATUS_WIDTH 16
`define USABLE_MASK 16'h7fff

// reset values of the two transition masks
`define NTR_RESET 16'h0000
`define PTR_RESET 16'h7fff

// slot count and the width of a slot index
`define SLOT_COUNT 4
`define SLOT_BITS 2

// offset type field inside a slot register
`define OFFSET_ENABLE_BIT 5
`define OFFSET_LO_BIT 6
`define OFFSET_HI_BIT 7
`define NON_OFFSET_MASK 16'hff3f

// cycles from a read command to its answer
`define RSP_LATENCY 1

`endif

// >>> hdl/status_pkg.sv
// types shared by the operation status transition filter
`include "status_cfg.svh"

package status_pkg;

  // commands accepted on the command port
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_NTR_WR = 3'b001,
    CMD_NTR_RD = 3'b010,
    CMD_PTR_WR = 3'b011,
    CMD_PTR_RD = 3'b100,
    CMD_EVT_RD = 3'b101
  } cmd_code_t;

  // two-bit offset type, bit 6 is the low bit
  typedef enum logic [1:0] {
    OFS_EXACT = 2'b00,
    OFS_BELOW = 2'b01,
    OFS_ABOVE = 2'b10,
    OFS_INTERP = 2'b11
  } offset_type_t;

  // one command from the host
  typedef struct packed {
    logic valid;
    cmd_code_t code;
    logic [`SLOT_BITS-1:0] slot;
    logic [`STATUS_WIDTH-1:0] data;
  } cmd_t;

  // one answer to a read command
  typedef struct packed {
    logic valid;
    logic [`STATUS_WIDTH-1:0] data;
  } rsp_t;

endpackage

// >>> testbench/host_model.sv
// host side model that issues status commands and collects answers
`include "status_cfg.svh"

module host_model import status_pkg::*; (
  input wire logic core_clk,
  input rsp_t rsp,
  output cmd_t cmd
);
  timeunit 1ns;
  timeprecision 1ns;

  initial cmd = '0;

  // mask write: one cycle of valid, no answer expected
  task wr(input cmd_code_t code, input logic [`STATUS_WIDTH-1:0] data);
    @(posedge core_clk);
    #1 cmd = {1'b1, code, 2'b00, data};
    @(posedge core_clk);
    #1 cmd = '0;
  endtask

  // read: answer stands for the cycle after the edge that takes the command
  task rd(input cmd_code_t code, input logic [`SLOT_BITS-1:0] slot, output logic [`STATUS_WIDTH-1:0] data);
    @(posedge core_clk);
    #1 cmd = {1'b1, code, slot, 16'h0000};
    @(posedge core_clk);
    #1 cmd = '0;
    data = (rsp.valid === 1'b1) ? rsp.data : 16'hxxxx; // missing answer never matches
  endtask
endmodule

// >>> testbench/tb_top.sv
// self-checking testbench for the operation status transition filter
`include "status_cfg.svh"

module tb_top import status_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  cmd_t cmd;
  rsp_t rsp;
  logic [`SLOT_COUNT-1:0][`STATUS_WIDTH-1:0] cond_in = '0;
  logic [`SLOT_COUNT-1:0][1:0] ofs;
  logic [`SLOT_COUNT-1:0] ofs_on;
  logic [`STATUS_WIDTH-1:0] d;
  int mismatches = 0;
  int compares = 0;

  // 25 mhz clock
  always #20 core_clk = ~core_clk;

  host_model i_host (.core_clk(core_clk), .rsp(rsp), .cmd(cmd));

  operation_status_transition_filter i_dut (
    .core_clk(core_clk),
    .rst(rst),
    .cmd(cmd),
    .cond_in(cond_in),
    .rsp(rsp),
    .offset_type(ofs),
    .offset_on(ofs_on)
  );

  // compare and count
  task chk(input logic [`STATUS_WIDTH-1:0] seen, input logic [`STATUS_WIDTH-1:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task results;
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // watchdog against a hung run
  initial begin
    #2000000;
    mismatches++;
    results();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    #1 rst = 1'b0;
    i_host.rd(CMD_NTR_RD, 2'd0, d);
    chk(d, 16'h0000);
    i_host.rd(CMD_PTR_RD, 2'd0, d);
    chk(d, 16'h7fff);
    i_host.wr(CMD_NTR_WR, 16'hffff);
    i_host.rd(CMD_NTR_RD, 2'd0, d);
    chk(d, 16'h7fff);
    i_host.wr(CMD_PTR_WR, 16'h0008);
    i_host.rd(CMD_PTR_RD, 2'd0, d);
    chk(d, 16'h0008);
    i_host.wr(CMD_NTR_WR, 16'h0010);
    // empty every slot before edge tests
    for (int s = 0; s < `SLOT_COUNT; s++) begin
      i_host.rd(CMD_EVT_RD, s[1:0], d);
    end
    // bit 3 rise is enabled, bit 4 rise is masked
    cond_in[1] = 16'h0018;
    tick(6);
    i_host.rd(CMD_EVT_RD, 2'd1, d);
    chk(d, 16'h0008);
    i_host.rd(CMD_EVT_RD, 2'd0, d);
    chk(d, 16'h0000);
    // bit 4 fall is enabled, bit 3 fall is masked
    cond_in[1] = 16'h0000;
    tick(6);
    i_host.rd(CMD_EVT_RD, 2'd1, d);
    chk(d, 16'h0010);
    i_host.rd(CMD_EVT_RD, 2'd1, d);
    chk(d, 16'h0000);
    // each offset type code on slots 0 and 2
    for (int k = 0; k < 4; k++) begin
      cond_in[0] = 16'h0020 | 16'(k << 6);
      cond_in[2] = 16'h0020 | 16'(k << 6);
      tick(3);
      chk({14'h0000, ofs[0]}, 16'(k));
      chk({14'h0000, ofs[2]}, 16'(k));
      chk({15'h0000, ofs_on[2]}, 16'h0001);
      i_host.rd(CMD_EVT_RD, 2'd2, d);
      chk(d & 16'h00c0, 16'(k << 6));
    end
    // type bits without the enable read as exact
    cond_in[2] = 16'h00c0;
    tick(3);
    chk({14'h0000, ofs[2]}, 16'h0000);
    chk({15'h0000, ofs_on[2]}, 16'h0000);
    results();
  end
endmodule
